// *** inc/sccm_params.svh ***
/*
 * Constants for the system clock and mode control block: selector codes,
 * source select encodings and divider range.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef SCCM_PARAMS_SVH
`define SCCM_PARAMS_SVH

`define SCCM_SEL_W        3
`define SCCM_SEL_SUB      3'h7
`define SCCM_SEL_RST      3'h0
`define SCCM_FAST_INT_RC  1'h0
`define SCCM_SLOW_INT_RC  1'h0
`define SCCM_DIV_W        6
`define SCCM_KEEP_RST     1'h0

`endif

// *** inc/sccm_pkg.sv ***
/*
 * Types for the system clock and mode control block.
 * Assumes the params header is compiled alongside.
 */
package sccm_pkg;

  // ****************************************************
  // Operating modes, one-hot
  // ****************************************************
  typedef enum logic [5:0] {
    SCCM_FAST  = 6'h01,
    SCCM_SLOW  = 6'h02,
    SCCM_SLEEP = 6'h04,
    SCCM_IDLE0 = 6'h08,
    SCCM_IDLE1 = 6'h10,
    SCCM_IDLE2 = 6'h20
  } sccm_mode_t;

  // Software control bits carried together
  typedef struct packed {
    logic [2:0] sys_clk_sel;
    logic       fast_src_sel;
    logic       slow_src_sel;
    logic       fast_osc_idle_keep;
    logic       slow_osc_idle_keep;
    logic       fast_osc_en;
  } sccm_ctrl_t;

  // Clock gate outputs carried together
  typedef struct packed {
    logic cpu_run;
    logic sys_run;
    logic fast_run;
    logic sub_run;
    logic low_rc_run;
  } sccm_gate_t;

endpackage : sccm_pkg

// *** rtl/sccm_top.sv ***
/*
 * System clock and operating mode control. Selects the high and low speed
 * sources, divides the fast clock, produces the system clock and tracks
 * the six operating modes, with halt and wake from the CPU.
 * Assumes oscillator inputs are square waves slower than core_clk, synchronised here into
 * core_clk; clocks here are core_clk-rate enable-style levels.
 */
// Notes on behaviour
// RULE1 - system clock from fast_clk or sub_clk
// RULE2 - fast_clk from crystal or fast RC
// RULE3 - sub_clk from crystal or slow RC
// RULE4 - fast mode divides fast_clk by 1..64
// RULE5 - fast oscillator follows enable after slow
// RULE6 - six modes, four with CPU off
// RULE7 - codes 000..110 running means FAST
// RULE8 - code 111 running means SLOW
// RULE9 - halt, both keeps low: SLEEP
// RULE10 - SLEEP keeps slow RC if watchdog on
// RULE11 - halt, slow keep only: IDLE0
// RULE12 - halt, both keeps high: IDLE1
// RULE13 - halt, fast keep only: IDLE2
// RULE14 - codes map to divide 1..64, sub
// RULE15 - fast_src_sel 0 is internal RC
// RULE16 - slow_src_sel 0 is internal RC
// RULE17 - mode latched at halt, wake resumes
// RULE18 - switching yields no runt clock pulses; a gate turning on while its source is high starts a short first pulse
`timescale 1ns/100ps
`include "sccm_params.svh"

module sccm_top #(
  parameter int DIV_W = `SCCM_DIV_W
) (
  input  wire logic               core_clk,        // Block clock
  input  wire logic               reset,           // Sync reset, high
  input  wire sccm_pkg::sccm_ctrl_t ctrl,          // Software control bits
  input  wire logic               wdt_en,          // Watchdog enabled
  input  wire logic               halt,            // Halt executed, pulse
  input  wire logic               wake,            // Wake event, pulse
  input  wire logic               ext_fast_crystal, // Fast crystal pin
  input  wire logic               int_fast_rc,     // Fast RC oscillator
  input  wire logic               ext_slow_crystal, // Slow crystal pin
  input  wire logic               int_slow_rc,     // Slow RC oscillator
  output sccm_pkg::sccm_mode_t    mode,            // Current mode
  output sccm_pkg::sccm_gate_t    gates,           // Run enables
  output logic                    sys_clk,         // System clock
  output logic                    fast_clk,        // Gated fast clock
  output logic                    sub_clk,         // Gated sub clock
  output logic                    low_rc_clock     // Gated slow RC clock
);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_w;

  assign pin_w = {ext_fast_crystal, int_fast_rc,
                  ext_slow_crystal, int_slow_rc};

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end
    else
    begin
      pin_s1_q <= pin_w;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ****************************************************
  // Source selection
  // ****************************************************
  logic fast_raw;
  logic sub_raw;
  logic rc_raw;

  assign fast_raw = (ctrl.fast_src_sel == `SCCM_FAST_INT_RC) ?
                    pin_s2_q[2] : pin_s2_q[3];          // [RULE2] [RULE15]
  assign sub_raw  = (ctrl.slow_src_sel == `SCCM_SLOW_INT_RC) ?
                    pin_s2_q[0] : pin_s2_q[1];          // [RULE3] [RULE16]
  assign rc_raw   = pin_s2_q[0];

  // ****************************************************
  // Operating mode machine
  // ****************************************************
  sccm_pkg::sccm_mode_t mode_q;
  sccm_pkg::sccm_mode_t mode_d;
  sccm_pkg::sccm_mode_t run_mode;
  sccm_pkg::sccm_mode_t halt_mode;
  logic                 sel_sub;

  assign sel_sub  = (ctrl.sys_clk_sel == `SCCM_SEL_SUB);
  assign run_mode = sel_sub ? sccm_pkg::SCCM_SLOW
                            : sccm_pkg::SCCM_FAST;      // [RULE7] [RULE8]
  assign halt_mode =
    ( ctrl.fast_osc_idle_keep &&  ctrl.slow_osc_idle_keep) ?
      sccm_pkg::SCCM_IDLE1 :                            // [RULE12]
    (!ctrl.fast_osc_idle_keep &&  ctrl.slow_osc_idle_keep) ?
      sccm_pkg::SCCM_IDLE0 :                            // [RULE11]
    ( ctrl.fast_osc_idle_keep && !ctrl.slow_osc_idle_keep) ?
      sccm_pkg::SCCM_IDLE2 :                            // [RULE13]
      sccm_pkg::SCCM_SLEEP;                             // [RULE9]

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      sccm_pkg::SCCM_FAST, sccm_pkg::SCCM_SLOW:
      begin
        if (halt)
          mode_d = halt_mode;                           // [RULE17]
        else
          mode_d = run_mode;
      end
      default:
      begin
        if (wake)
          mode_d = run_mode;                            // [RULE17]
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      mode_q <= sccm_pkg::SCCM_FAST;
    else
      mode_q <= mode_d;                                 // [RULE6]
  end

  assign mode = mode_q;

  // ****************************************************
  // Gate decode per mode
  // ****************************************************
  logic cpu_on;
  logic fast_on;
  logic sub_on;
  logic sys_on;
  logic rc_on;

  assign cpu_on  = (mode_q == sccm_pkg::SCCM_FAST) ||
                   (mode_q == sccm_pkg::SCCM_SLOW);     // [RULE6]
  // Slow mode keeps the fast oscillator only if enabled
  assign fast_on = (mode_q == sccm_pkg::SCCM_FAST)  ||
                   (mode_q == sccm_pkg::SCCM_IDLE1) ||
                   (mode_q == sccm_pkg::SCCM_IDLE2) ||
                   ((mode_q == sccm_pkg::SCCM_SLOW) &&
                    ctrl.fast_osc_en);                  // [RULE5] [RULE8]
  assign sub_on  = (mode_q != sccm_pkg::SCCM_SLEEP) &&
                   (mode_q != sccm_pkg::SCCM_IDLE2);    // [RULE9] [RULE13]
  assign sys_on  = cpu_on ||
                   (mode_q == sccm_pkg::SCCM_IDLE1) ||  // [RULE12]
                   ((mode_q == sccm_pkg::SCCM_IDLE0) && sel_sub) ||
                   ((mode_q == sccm_pkg::SCCM_IDLE2) && !sel_sub);
  assign rc_on   = (mode_q != sccm_pkg::SCCM_SLEEP) || wdt_en; // [RULE10]

  // ****************************************************
  // Fast clock divider
  // ****************************************************
  logic             fast_prev_q;
  logic             fast_rise;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W:0]   taps;
  logic             fast_div;

  assign fast_rise = fast_raw && !fast_prev_q;
  assign div_d     = fast_rise ? div_q + {{(DIV_W-1){1'b0}}, 1'b1} : div_q;
  assign taps      = {div_q, fast_raw};                 // [RULE4]

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fast_prev_q <= 1'b0;
      div_q       <= '0;
    end
    else
    begin
      fast_prev_q <= fast_raw;
      div_q       <= div_d;
    end
  end

  // ****************************************************
  // Glitch-free system clock select
  // ****************************************************
  // A new choice is adopted only when both the current and the target
  // clock are low, so no high phase is cut short.
  logic [2:0] cur_sel_q;
  logic [2:0] cur_sel_d;
  logic       cur_src;
  logic       tgt_src;
  logic       src_mux;

  function automatic logic pick(input logic [2:0] s,
                                input logic [DIV_W:0] t,
                                input logic sc);
    pick = (s == `SCCM_SEL_SUB) ? sc : t[s];            // [RULE14]
  endfunction : pick

  assign cur_src   = pick(cur_sel_q, taps, sub_raw);    // [RULE1]
  assign tgt_src   = pick(ctrl.sys_clk_sel, taps, sub_raw);
  assign cur_sel_d = (!cur_src && !tgt_src) ?
                     ctrl.sys_clk_sel : cur_sel_q;      // [RULE18]
  assign src_mux   = cur_src;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      cur_sel_q <= `SCCM_SEL_RST;
    else
      cur_sel_q <= cur_sel_d;
  end

  // ****************************************************
  // Registered clock outputs
  // ****************************************************
  // Gates turn off only while the clock is low, keeping the last pulse whole; turning on can start mid-pulse.
  logic sys_q;
  logic fast_q;
  logic sub_q;
  logic rc_q;
  logic fast_div_unused;

  assign fast_div        = taps[0];
  assign fast_div_unused = fast_div;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sys_q  <= 1'b0;
      fast_q <= 1'b0;
      sub_q  <= 1'b0;
      rc_q   <= 1'b0;
    end
    else
    begin
      sys_q  <= src_mux  && (sys_on  || sys_q);          // [RULE18]
      fast_q <= fast_raw && (fast_on || fast_q);
      sub_q  <= sub_raw  && (sub_on  || sub_q);
      rc_q   <= rc_raw   && (rc_on   || rc_q);
    end
  end

  assign sys_clk      = sys_q;
  assign fast_clk     = fast_q;
  assign sub_clk      = sub_q;
  assign low_rc_clock = rc_q;
  assign gates        = '{cpu_run: cpu_on, sys_run: sys_on,
                          fast_run: fast_on, sub_run: sub_on,
                          low_rc_run: rc_on};

endmodule : sccm_top

// *** tb/sccm_top_sva.sv ***
/* Mode and gate checker for sccm_top.
   Bound to sccm_top; sees its ports only. */
`timescale 1ns/100ps
module sccm_sva #(parameter int DIV_W = 6) (
  input wire logic                 core_clk, // Clock
  input wire logic                 reset,    // Reset
  input wire sccm_pkg::sccm_ctrl_t ctrl,     // Control
  input wire logic                 wdt_en,   // Watchdog
  input wire logic                 halt,     // Halt
  input wire logic                 wake,     // Wake
  input wire sccm_pkg::sccm_mode_t mode,     // Mode
  input wire sccm_pkg::sccm_gate_t gates     // Gates
);
  // ****
  // Mode decode
  // ****
  wire       m_f = mode == sccm_pkg::SCCM_FAST;
  wire       run = m_f | (mode == sccm_pkg::SCCM_SLOW);
  wire       s7  = ctrl.sys_clk_sel == 3'h7;
  wire [1:0] k   = {ctrl.fast_osc_idle_keep, ctrl.slow_osc_idle_keep};
  wire       hs  = halt & run;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_sleep; hs && k == 2'h0 |=> mode == 6'h04; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_idle0; hs && k == 2'h1 |=> mode == 6'h08; endproperty
  a_idle0: assert property (p_idle0) else $error("no idle0");
  property p_idle1; hs && k == 2'h3 |=> mode == 6'h10; endproperty
  a_idle1: assert property (p_idle1) else $error("no idle1");
  property p_idle2; hs && k == 2'h2 |=> mode == 6'h20; endproperty
  a_idle2: assert property (p_idle2) else $error("no idle2");
  property p_fast; run && !halt && !s7 |=> m_f; endproperty
  a_fast: assert property (p_fast) else $error("no fast");
  property p_wake; !run && wake && s7 |=> mode == 6'h02; endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_hold; !run && !wake |=> $stable(mode); endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_cpu; gates.cpu_run == run; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu gate");
  property p_slp; mode == 6'h04 |-> !gates.sys_run && !gates.fast_run &&
    !gates.sub_run && gates.low_rc_run == wdt_en; endproperty
  a_slp: assert property (p_slp) else $error("sleep gates");
  c_sleep: cover property (hs && k == 2'h0);
  c_idle1: cover property (hs && k == 2'h3);
  c_wake: cover property (!run && wake);
endmodule : sccm_sva

bind sccm_top sccm_sva #(.DIV_W(DIV_W)) sccm_sva_inst (.core_clk, .reset,
  .ctrl, .wdt_en, .halt, .wake, .mode, .gates);

// *** tb/tb_sccm_top.sv ***
/* Bench for sccm_top: division, sources, low-power modes, refusals.
   Assumes package, header, design and checker compiled first. */
`timescale 1ns/100ps
module tb_sccm_top;
  // ****
  // Stimulus and edge counters
  // ****
  logic                 core_clk, reset, wdt_en, halt, wake;
  logic                 sys_clk, fast_clk, sub_clk, low_rc_clock;
  sccm_pkg::sccm_ctrl_t ctrl;
  sccm_pkg::sccm_mode_t mode;
  sccm_pkg::sccm_gate_t gates;
  logic [5:0]           ph;
  logic [3:0]           pv;
  logic [15:0]          n_s, n_f, n_u, d_s, d_f, d_u;
  logic [15:0]          n_r, d_r;
  int                   error_cnt, comparisons;
  localparam logic [5:0] MT [4] = '{6'h04, 6'h08, 6'h20, 6'h10};
  sccm_top #(.DIV_W(6)) sccm_top_inst (.core_clk, .reset, .ctrl, .wdt_en,
    .halt, .wake, .ext_fast_crystal(ph[1]), .int_fast_rc(ph[0]),
    .ext_slow_crystal(ph[4]), .int_slow_rc(ph[3]), .mode, .gates,
    .sys_clk, .fast_clk, .sub_clk, .low_rc_clock);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    ph <= ph + 6'h01;
    pv <= {low_rc_clock, sys_clk, fast_clk, sub_clk};
    n_r <= n_r + {15'h0000, low_rc_clock & ~pv[3]};
    n_s <= n_s + {15'h0000, sys_clk & ~pv[2]};
    n_f <= n_f + {15'h0000, fast_clk & ~pv[1]};
    n_u <= n_u + {15'h0000, sub_clk & ~pv[0]};
  end
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cnt(input logic [15:0] got, exp);
    chk((got + 16'h0001 >= exp && got <= exp + 16'h0001) ? exp : got, exp);
  endtask : chk_cnt
  task automatic meas;
    logic [15:0] a, b, c, r;
    repeat (300) @(posedge core_clk);
    r = n_r;
    a = n_s;
    b = n_f;
    c = n_u;
    repeat (256) @(posedge core_clk);
    d_s = n_s - a;
    d_f = n_f - b;
    d_u = n_u - c;
    d_r = n_r - r;
  endtask : meas
  task automatic cfg(input logic [7:0] v);
    @(posedge core_clk);
    ctrl <= v;
  endtask : cfg
  task automatic pulse(input logic h);
    @(posedge core_clk);
    halt <= h;
    wake <= ~h;
    @(posedge core_clk);
    halt <= 1'b0;
    wake <= 1'b0;
    #1;
  endtask : pulse
  task automatic s_div;
    for (int k = 0; k < 7; k++)
    begin
      cfg({k[2:0], 5'h01});
      meas();
      chk(mode, 6'h01);
      chk_cnt(d_s, 16'h0080 >> k);
    end
  endtask : s_div
  task automatic s_src;
    cfg(8'h01);
    meas();
    chk_cnt(d_f, 16'd128);
    chk_cnt(d_u, 16'd16);
    cfg(8'h19);
    meas();
    chk_cnt(d_f, 16'd64);
    chk_cnt(d_u, 16'd8);
    cfg(8'hE9);
    meas();
    chk(mode, 6'h02);
    chk_cnt(d_s, 16'd8);
    chk_cnt(d_f, 16'd128);
    cfg(8'hE8);
    meas();
    chk_cnt(d_f, 16'd0);
  endtask : s_src
  task automatic s_low;
    for (int i = 0; i < 8; i++)
    begin
      cfg({i[2] ? 3'h7 : 3'h0, 2'h0, i[1:0], 1'h1});
      wdt_en <= i[2];
      meas();
      pulse(1'b1);
      chk(mode, MT[i[1:0]]);
      chk(gates.cpu_run, 1'b0);
      chk(gates.low_rc_run, i[1:0] != 0 || i[2]);
      meas();
      chk_cnt(d_f, i[1] ? 16'd128 : 16'd0);
      chk_cnt(d_u, i[0] ? 16'd16 : 16'd0);
      chk_cnt(d_r, (i[1:0] != 0 || i[2]) ? 16'd16 : 16'd0);
      chk_cnt(d_s, (i % 4 == 3 || i == 5 || i == 2) ?
        (i[2] ? 16'd16 : 16'd128) : 16'd0);
      pulse(1'b0);
      chk(mode, i[2] ? 6'h02 : 6'h01);
    end
  endtask : s_low
  task automatic s_refuse;
    cfg(8'h07);
    pulse(1'b0);
    chk(mode, 6'h01);
    pulse(1'b1);
    chk(mode, 6'h10);
    cfg(8'h01);
    pulse(1'b1);
    chk(mode, 6'h10);
    pulse(1'b0);
    chk(mode, 6'h01);
  endtask : s_refuse
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    {reset, wdt_en, halt, wake, ctrl} = {4'h8, 8'h01};
    {ph, pv, n_s, n_f, n_u, n_r} = '0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    s_div();
    s_src();
    s_low();
    s_refuse();
    conclude();
  end
endmodule : tb_sccm_top
